// [common/mps_pkg.sv]
// Shared constants for the multifunction pin select block
package mps_pkg;

  ////////////////////////////////////////////////////////////////
  // Register space placement
  localparam logic [7:0] BOOK_SEL = 8'h00;
  localparam logic [7:0] PAGE_SEL = 8'h01;

  // Register offsets within the page
  localparam logic [7:0] PIN_B_OFS = 8'h3e;
  localparam logic [7:0] PIN_C_OFS = 8'h3f;
  localparam logic [7:0] PIN_D_OFS = 8'h40;

  // Reset values
  localparam logic [7:0] PIN_B_RST = 8'h01;
  localparam logic [7:0] PIN_C_RST = 8'h10;
  localparam logic [7:0] PIN_D_RST = 8'h07;

  // Read value of an unmapped location
  localparam logic [7:0] RD_NONE = 8'h00;

  ////////////////////////////////////////////////////////////////
  // Field layout
  localparam int SEL_MSB = 4;
  localparam int SEL_LSB = 0;
  localparam int LEVEL_BIT = 6;

  // Select field type
  typedef logic [4:0] mps_sel_t;

  ////////////////////////////////////////////////////////////////
  // Select codes
  localparam mps_sel_t SEL_OFF = 5'h00;
  localparam mps_sel_t SEL_INPUT = 5'h01;
  localparam mps_sel_t SEL_STATIC = 5'h03;
  localparam mps_sel_t SEL_BITBANG = 5'h04;
  localparam mps_sel_t SEL_PDM_CLK = 5'h05;
  localparam mps_sel_t SEL_ALT6 = 5'h06;
  localparam mps_sel_t SEL_IRQ1 = 5'h07;
  localparam mps_sel_t SEL_IRQ2 = 5'h08;
  localparam mps_sel_t SEL_IRQ3 = 5'h09;
  localparam mps_sel_t SEL_IRQ4 = 5'h0a;
  localparam mps_sel_t SEL_P1_WCLK_A = 5'h0c;
  localparam mps_sel_t SEL_P1_BCLK = 5'h0d;
  localparam mps_sel_t SEL_P1_DOUT = 5'h10;
  localparam mps_sel_t SEL_P1_WCLK_B = 5'h11;
  localparam mps_sel_t SEL_P2_BCLK = 5'h12;
  localparam mps_sel_t SEL_P2_DOUT = 5'h15;
  localparam mps_sel_t SEL_M_WCLK = 5'h1b;
  localparam mps_sel_t SEL_M_BCLK = 5'h1c;
  localparam mps_sel_t SEL_M_DOUT = 5'h1d;

  // Which pin a selector instance serves
  typedef enum {
    MPS_PIN_B,
    MPS_PIN_C,
    MPS_PIN_D
  } mps_pin_t;

endpackage

// [design/mps_pin_mux.sv]
// Per-pin function decoder with registered pin controls
`timescale 1ns/1ps
`default_nettype none

module mps_pin_mux #(
  parameter mps_pkg::mps_pin_t VARIANT = mps_pkg::MPS_PIN_B
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Configuration
  input wire logic [4:0] select_i,
  input wire logic static_level_i,
  // Synchronised pin level
  input wire logic pin_sync_i,
  // Output sources
  input wire logic shared_bitbang_level_i,
  input wire logic pdm_clock_i,
  input wire logic general_clock_output_i,
  input wire logic irq_line_zero_i,
  input wire logic irq_line_one_i,
  input wire logic irq_line_two_i,
  input wire logic irq_line_three_i,
  input wire logic irq_line_four_i,
  input wire logic port_one_word_clock_out_i,
  input wire logic port_one_bit_clock_out_i,
  input wire logic port_one_data_out_i,
  input wire logic port_two_bit_clock_out_i,
  input wire logic port_two_data_out_i,
  input wire logic merged_port_word_clock_out_i,
  input wire logic merged_port_bit_clock_out_i,
  input wire logic merged_port_data_out_i,
  // Pin controls
  output logic pin_out_o,
  output logic pin_oe_o,
  output logic pin_ie_o,
  output logic route_o
);

  logic out_next; // Level to drive
  logic oe_next; // Output buffer on
  logic ie_next; // Input buffer on

  // Decode the select code; anything not listed leaves both buffers off
  always_comb begin
    out_next = 1'b0;
    oe_next = 1'b1;
    ie_next = 1'b0;
    case (select_i)
      mps_pkg::SEL_OFF: oe_next = 1'b0; // [RULE1]
      mps_pkg::SEL_INPUT: begin
        oe_next = 1'b0; // [RULE2]
        ie_next = 1'b1;
      end
      mps_pkg::SEL_STATIC: out_next = static_level_i; // [RULE3]
      mps_pkg::SEL_BITBANG: out_next = shared_bitbang_level_i; // [RULE4]
      mps_pkg::SEL_PDM_CLK: out_next = pdm_clock_i; // [RULE5]
      mps_pkg::SEL_ALT6: begin
        // Code 6 differs per pin
        if (VARIANT == mps_pkg::MPS_PIN_B) begin
          out_next = general_clock_output_i; // [RULE6]
        end else if (VARIANT == mps_pkg::MPS_PIN_C) begin
          out_next = irq_line_one_i; // [RULE8]
        end else begin
          out_next = irq_line_zero_i; // [RULE9]
        end
      end
      mps_pkg::SEL_IRQ1: begin
        // No function for code 7 on pin c
        if (VARIANT == mps_pkg::MPS_PIN_C) begin
          oe_next = 1'b0; // [RULE8] [RULE14]
        end else begin
          out_next = irq_line_one_i; // [RULE7]
        end
      end
      mps_pkg::SEL_IRQ2: out_next = irq_line_two_i; // [RULE7] [RULE8]
      mps_pkg::SEL_IRQ3: out_next = irq_line_three_i; // [RULE7] [RULE8]
      mps_pkg::SEL_IRQ4: out_next = irq_line_four_i; // [RULE7] [RULE8]
      mps_pkg::SEL_P1_WCLK_A: out_next = port_one_word_clock_out_i; // [RULE10]
      mps_pkg::SEL_P1_BCLK: out_next = port_one_bit_clock_out_i; // [RULE10]
      mps_pkg::SEL_P1_DOUT: out_next = port_one_data_out_i; // [RULE11]
      mps_pkg::SEL_P1_WCLK_B: out_next = port_one_word_clock_out_i; // [RULE11]
      mps_pkg::SEL_P2_BCLK: out_next = port_two_bit_clock_out_i; // [RULE11]
      mps_pkg::SEL_P2_DOUT: out_next = port_two_data_out_i; // [RULE12]
      mps_pkg::SEL_M_WCLK: out_next = merged_port_word_clock_out_i; // [RULE13]
      mps_pkg::SEL_M_BCLK: out_next = merged_port_bit_clock_out_i; // [RULE13]
      mps_pkg::SEL_M_DOUT: out_next = merged_port_data_out_i; // [RULE13]
      default: oe_next = 1'b0; // Reserved codes float the pin [RULE12] [RULE14]
    endcase
  end

  // Register pin controls so the pad sees glitch-free levels
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_out_o <= 1'b0;
      pin_oe_o <= 1'b0;
      pin_ie_o <= 1'b0;
      route_o <= 1'b0;
    end else begin
      pin_out_o <= out_next;
      pin_oe_o <= oe_next;
      pin_ie_o <= ie_next;
      route_o <= ie_next & pin_sync_i; // [RULE2]
    end
  end

endmodule

`default_nettype wire

// [design/mps_pin_select.sv]
// Multifunction pin select: registers, input synchronisers, three pin selectors
//
// Operation
// [RULE1] Code 0 disables pin, both buffers off
// [RULE2] Code 1 routes pin to input mux
// [RULE3] Code 3 drives stored static level bit
// [RULE4] Code 4 drives shared bit-bang level
// [RULE5] Code 5 drives pulse-density sampling clock
// [RULE6] Pin b code 6 drives clock out
// [RULE7] Pins b,d codes 7-10 drive irq 1-4
// [RULE8] Pin c: 6 irq1, 8-10 irq2-4
// [RULE9] Pin d code 6 drives irq zero
// [RULE10] Codes 12,13: port one word, bit clock
// [RULE11] Codes 16-18: p1 data, p1 wclk, p2 bclk
// [RULE12] Code 21 port two data; others reserved
// [RULE13] Codes 27-29: merged port wclk, bclk, data
// [RULE14] Reserved codes leave output buffer undriven
`timescale 1ns/1ps
`default_nettype none

module mps_pin_select (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,

  // Register access port
  input wire logic [7:0] reg_book_i,
  input wire logic [7:0] reg_page_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,

  // Output sources from the rest of the device
  input wire logic shared_bitbang_level_i,
  input wire logic pdm_clock_i,
  input wire logic general_clock_output_i,
  input wire logic irq_line_zero_i,
  input wire logic irq_line_one_i,
  input wire logic irq_line_two_i,
  input wire logic irq_line_three_i,
  input wire logic irq_line_four_i,
  input wire logic port_one_word_clock_out_i,
  input wire logic port_one_bit_clock_out_i,
  input wire logic port_one_data_out_i,
  input wire logic port_two_bit_clock_out_i,
  input wire logic port_two_data_out_i,
  input wire logic merged_port_word_clock_out_i,
  input wire logic merged_port_bit_clock_out_i,
  input wire logic merged_port_data_out_i,

  // Pin b pad
  input wire logic pin_b_i,
  output logic pin_b_o,
  output logic pin_b_oe_o,
  output logic pin_b_ie_o,

  // Pin c pad
  input wire logic pin_c_i,
  output logic pin_c_o,
  output logic pin_c_oe_o,
  output logic pin_c_ie_o,

  // Pin d pad
  input wire logic pin_d_i,
  output logic pin_d_o,
  output logic pin_d_oe_o,
  output logic pin_d_ie_o,

  // Routed input levels toward the input multiplexer
  output logic pin_b_route_o,
  output logic pin_c_route_o,
  output logic pin_d_route_o
);

  ////////////////////////////////////////////////////////////////
  // Address decode

  // True when the access lands on the given register
  function automatic logic hit(
    input logic [7:0] book,
    input logic [7:0] page,
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    hit = (book == mps_pkg::BOOK_SEL) && (page == mps_pkg::PAGE_SEL) && (addr == ofs);
  endfunction

  logic hit_b; // Access targets pin b register
  logic hit_c; // Access targets pin c register
  logic hit_d; // Access targets pin d register

  assign hit_b = hit(reg_book_i, reg_page_i, reg_addr_i, mps_pkg::PIN_B_OFS);
  assign hit_c = hit(reg_book_i, reg_page_i, reg_addr_i, mps_pkg::PIN_C_OFS);
  assign hit_d = hit(reg_book_i, reg_page_i, reg_addr_i, mps_pkg::PIN_D_OFS);

  ////////////////////////////////////////////////////////////////
  // Pin registers

  // Reserved bits 7 and 5 are plain read/write storage and steer nothing
  logic [7:0] pin_b_function_select_reg;
  logic [7:0] pin_c_function_select_reg;
  logic [7:0] pin_d_function_select_reg;

  // Pin b register write
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_b_function_select_reg <= mps_pkg::PIN_B_RST;
    end else if (reg_wr_i && hit_b) begin
      pin_b_function_select_reg <= reg_wdata_i; // [RULE1]
    end
  end

  // Pin c register write
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_c_function_select_reg <= mps_pkg::PIN_C_RST;
    end else if (reg_wr_i && hit_c) begin
      pin_c_function_select_reg <= reg_wdata_i; // [RULE1]
    end
  end

  // Pin d register write
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_d_function_select_reg <= mps_pkg::PIN_D_RST;
    end else if (reg_wr_i && hit_d) begin
      pin_d_function_select_reg <= reg_wdata_i; // [RULE1]
    end
  end

  // Fields split out of the registers
  logic [4:0] pin_b_select;
  logic [4:0] pin_c_select;
  logic [4:0] pin_d_select;
  logic pin_b_static_level;
  logic pin_c_static_level;
  logic pin_d_static_level;

  assign pin_b_select = pin_b_function_select_reg[mps_pkg::SEL_MSB:mps_pkg::SEL_LSB];
  assign pin_c_select = pin_c_function_select_reg[mps_pkg::SEL_MSB:mps_pkg::SEL_LSB];
  assign pin_d_select = pin_d_function_select_reg[mps_pkg::SEL_MSB:mps_pkg::SEL_LSB];
  assign pin_b_static_level = pin_b_function_select_reg[mps_pkg::LEVEL_BIT]; // [RULE3]
  assign pin_c_static_level = pin_c_function_select_reg[mps_pkg::LEVEL_BIT]; // [RULE3]
  assign pin_d_static_level = pin_d_function_select_reg[mps_pkg::LEVEL_BIT]; // [RULE3]

  ////////////////////////////////////////////////////////////////
  // Register read

  logic [7:0] rdata_next; // Read data of this access

  // Unmapped reads return zero
  always_comb begin
    if (hit_b) begin
      rdata_next = pin_b_function_select_reg;
    end else if (hit_c) begin
      rdata_next = pin_c_function_select_reg;
    end else if (hit_d) begin
      rdata_next = pin_d_function_select_reg;
    end else begin
      rdata_next = mps_pkg::RD_NONE;
    end
  end

  // Read data held until the next read; valid pulses one cycle
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= mps_pkg::RD_NONE;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pad input synchronisers

  // Pads are asynchronous; only the second stage is read
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;

  // Two-stage synchroniser for all three pads
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= {pin_d_i, pin_c_i, pin_b_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin selectors

  // Pin b selector
  mps_pin_mux #(
    .VARIANT(mps_pkg::MPS_PIN_B)
  ) u_pin_b (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .select_i(pin_b_select),
    .static_level_i(pin_b_static_level),
    .pin_sync_i(pin_sync_reg[0]),
    .shared_bitbang_level_i(shared_bitbang_level_i),
    .pdm_clock_i(pdm_clock_i),
    .general_clock_output_i(general_clock_output_i),
    .irq_line_zero_i(irq_line_zero_i),
    .irq_line_one_i(irq_line_one_i),
    .irq_line_two_i(irq_line_two_i),
    .irq_line_three_i(irq_line_three_i),
    .irq_line_four_i(irq_line_four_i),
    .port_one_word_clock_out_i(port_one_word_clock_out_i),
    .port_one_bit_clock_out_i(port_one_bit_clock_out_i),
    .port_one_data_out_i(port_one_data_out_i),
    .port_two_bit_clock_out_i(port_two_bit_clock_out_i),
    .port_two_data_out_i(port_two_data_out_i),
    .merged_port_word_clock_out_i(merged_port_word_clock_out_i),
    .merged_port_bit_clock_out_i(merged_port_bit_clock_out_i),
    .merged_port_data_out_i(merged_port_data_out_i),
    .pin_out_o(pin_b_o),
    .pin_oe_o(pin_b_oe_o),
    .pin_ie_o(pin_b_ie_o),
    .route_o(pin_b_route_o)
  );

  // Pin c selector
  mps_pin_mux #(
    .VARIANT(mps_pkg::MPS_PIN_C)
  ) u_pin_c (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .select_i(pin_c_select),
    .static_level_i(pin_c_static_level),
    .pin_sync_i(pin_sync_reg[1]),
    .shared_bitbang_level_i(shared_bitbang_level_i),
    .pdm_clock_i(pdm_clock_i),
    .general_clock_output_i(general_clock_output_i),
    .irq_line_zero_i(irq_line_zero_i),
    .irq_line_one_i(irq_line_one_i),
    .irq_line_two_i(irq_line_two_i),
    .irq_line_three_i(irq_line_three_i),
    .irq_line_four_i(irq_line_four_i),
    .port_one_word_clock_out_i(port_one_word_clock_out_i),
    .port_one_bit_clock_out_i(port_one_bit_clock_out_i),
    .port_one_data_out_i(port_one_data_out_i),
    .port_two_bit_clock_out_i(port_two_bit_clock_out_i),
    .port_two_data_out_i(port_two_data_out_i),
    .merged_port_word_clock_out_i(merged_port_word_clock_out_i),
    .merged_port_bit_clock_out_i(merged_port_bit_clock_out_i),
    .merged_port_data_out_i(merged_port_data_out_i),
    .pin_out_o(pin_c_o),
    .pin_oe_o(pin_c_oe_o),
    .pin_ie_o(pin_c_ie_o),
    .route_o(pin_c_route_o)
  );

  // Pin d selector; the only pin that can carry irq line zero
  mps_pin_mux #(
    .VARIANT(mps_pkg::MPS_PIN_D)
  ) u_pin_d (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .select_i(pin_d_select),
    .static_level_i(pin_d_static_level),
    .pin_sync_i(pin_sync_reg[2]),
    .shared_bitbang_level_i(shared_bitbang_level_i),
    .pdm_clock_i(pdm_clock_i),
    .general_clock_output_i(general_clock_output_i),
    .irq_line_zero_i(irq_line_zero_i),
    .irq_line_one_i(irq_line_one_i),
    .irq_line_two_i(irq_line_two_i),
    .irq_line_three_i(irq_line_three_i),
    .irq_line_four_i(irq_line_four_i),
    .port_one_word_clock_out_i(port_one_word_clock_out_i),
    .port_one_bit_clock_out_i(port_one_bit_clock_out_i),
    .port_one_data_out_i(port_one_data_out_i),
    .port_two_bit_clock_out_i(port_two_bit_clock_out_i),
    .port_two_data_out_i(port_two_data_out_i),
    .merged_port_word_clock_out_i(merged_port_word_clock_out_i),
    .merged_port_bit_clock_out_i(merged_port_bit_clock_out_i),
    .merged_port_data_out_i(merged_port_data_out_i),
    .pin_out_o(pin_d_o),
    .pin_oe_o(pin_d_oe_o),
    .pin_ie_o(pin_d_ie_o),
    .route_o(pin_d_route_o)
  );

endmodule

`default_nettype wire

// [sim/mps_pin_select_props.sv]
// Port-level checker of the pin select block
`timescale 1ns/1ps
`default_nettype none

module mps_pin_select_props (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Register access
  input wire logic [7:0] reg_book_i,
  input wire logic [7:0] reg_page_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // Sources watched
  input wire logic shared_bitbang_level_i,
  input wire logic pdm_clock_i,
  input wire logic general_clock_output_i,
  input wire logic irq_line_zero_i,
  input wire logic irq_line_one_i,
  // Pads watched
  input wire logic pin_b_i,
  input wire logic pin_b_o,
  input wire logic pin_b_oe_o,
  input wire logic pin_b_ie_o,
  input wire logic pin_b_route_o,
  input wire logic pin_c_o,
  input wire logic pin_c_oe_o,
  input wire logic pin_c_ie_o,
  input wire logic pin_d_o,
  input wire logic pin_d_oe_o
);
  ////////////////////////////////////////////////////////////////
  logic [7:0] shb_reg, shc_reg, shd_reg; // Shadow copies of the registers
  logic [4:0] sb, sc, sd; // Shadow select fields
  logic [2:0] age_reg; // Edges since reset, saturating
  logic hit; // Book and page match
  logic [7:0] rd_exp; // Read value expected now
  logic run; // Out of reset a cycle
  assign run = age_reg != 3'h0;
  assign hit = reg_book_i == mps_pkg::BOOK_SEL && reg_page_i == mps_pkg::PAGE_SEL;
  assign sb = shb_reg[4:0];
  assign sc = shc_reg[4:0];
  assign sd = shd_reg[4:0];
  assign rd_exp = !hit ? mps_pkg::RD_NONE : reg_addr_i == mps_pkg::PIN_B_OFS ? shb_reg :
    reg_addr_i == mps_pkg::PIN_C_OFS ? shc_reg : reg_addr_i == mps_pkg::PIN_D_OFS ? shd_reg : mps_pkg::RD_NONE;

  // Shadows follow only writes that hit
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shb_reg <= mps_pkg::PIN_B_RST;
      shc_reg <= mps_pkg::PIN_C_RST;
      shd_reg <= mps_pkg::PIN_D_RST;
    end else if (reg_wr_i && hit) begin
      if (reg_addr_i == mps_pkg::PIN_B_OFS) shb_reg <= reg_wdata_i;
      if (reg_addr_i == mps_pkg::PIN_C_OFS) shc_reg <= reg_wdata_i;
      if (reg_addr_i == mps_pkg::PIN_D_OFS) shd_reg <= reg_wdata_i;
    end
  end

  // Age keeps checks off edges that look back into reset
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) age_reg <= 3'h0;
    else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  property p_off;
    run && $past(sb) == mps_pkg::SEL_OFF |-> !pin_b_oe_o && !pin_b_ie_o;
  endproperty
  a_off: assert property (p_off) else $error("b on while off");
  property p_route;
    age_reg > 3'h3 && $past(sb) == mps_pkg::SEL_INPUT && $past(sb, 3) == mps_pkg::SEL_INPUT
      |-> pin_b_ie_o && !pin_b_oe_o && pin_b_route_o == $past(pin_b_i, 3);
  endproperty
  a_route: assert property (p_route) else $error("b input path");
  property p_static;
    run && $past(sb) == mps_pkg::SEL_STATIC |-> pin_b_oe_o && pin_b_o == $past(shb_reg[6]);
  endproperty
  a_static: assert property (p_static) else $error("b static level");
  property p_bitbang;
    run && $past(sd) == mps_pkg::SEL_BITBANG |-> pin_d_oe_o && pin_d_o == $past(shared_bitbang_level_i);
  endproperty
  a_bitbang: assert property (p_bitbang) else $error("d bit-bang level");
  property p_pdm;
    run && $past(sc) == mps_pkg::SEL_PDM_CLK |-> pin_c_oe_o && pin_c_o == $past(pdm_clock_i);
  endproperty
  a_pdm: assert property (p_pdm) else $error("c pdm clock");
  property p_general_clock_output;
    run && $past(sb) == mps_pkg::SEL_ALT6 |-> pin_b_oe_o && pin_b_o == $past(general_clock_output_i);
  endproperty
  a_general_clock_output: assert property (p_general_clock_output) else $error("b clock out");
  property p_c_irq;
    run && $past(sc) == mps_pkg::SEL_ALT6 |-> pin_c_oe_o && pin_c_o == $past(irq_line_one_i);
  endproperty
  a_c_irq: assert property (p_c_irq) else $error("c irq one");
  property p_d_irq;
    run && $past(sd) == mps_pkg::SEL_ALT6 |-> pin_d_oe_o && pin_d_o == $past(irq_line_zero_i);
  endproperty
  a_d_irq: assert property (p_d_irq) else $error("d irq zero");
  property p_resv;
    run && $past(sc) == mps_pkg::SEL_IRQ1 |-> !pin_c_oe_o && !pin_c_ie_o && !pin_c_o;
  endproperty
  a_resv: assert property (p_resv) else $error("c code 7 driven");
  property p_read;
    reg_rd_i |-> ##1 reg_rvalid_o && reg_rdata_o == $past(rd_exp);
  endproperty
  a_read: assert property (p_read) else $error("read answer");
  property p_rvalid;
    reg_rvalid_o |-> $past(reg_rd_i);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("stray read valid");

  // Main scenarios reached
  c_write: cover property (reg_wr_i && hit);
  c_input: cover property (pin_b_ie_o && pin_b_route_o);
  c_static: cover property (pin_b_oe_o && $past(sb) == mps_pkg::SEL_STATIC);
endmodule

bind mps_pin_select mps_pin_select_props i_mps_pin_select_props (.*);

`default_nettype wire

// [sim/mps_far_side.sv]
// Far side model: source levels of the device and outside pad drivers
`timescale 1ns/1ps
`default_nettype none

module mps_far_side (
  // Stimulus from the bench
  input wire logic [15:0] pattern_i,
  input wire logic [2:0] ext_i,
  // Pad controls from the block
  input wire logic [2:0] pad_out_i,
  input wire logic [2:0] pad_oe_i,
  // Levels toward the block
  output logic [15:0] src_o,
  output logic [2:0] pad_o
);
  // Same-clock sources follow the pattern directly
  assign src_o = pattern_i;

  // The block wins while it drives, else the outside driver
  assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule

`default_nettype wire

// [sim/tb.sv]
// Self-checking bench of the pin select block
`timescale 1ns/1ps
`default_nettype none

module tb;
  ////////////////////////////////////////////////////////////////
  logic clk_sys_i, arst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic [7:0] reg_book_i, reg_page_i, reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic shared_bitbang_level_i, pdm_clock_i, general_clock_output_i, irq_line_zero_i, irq_line_one_i;
  logic irq_line_two_i, irq_line_three_i, irq_line_four_i, port_one_word_clock_out_i, port_one_bit_clock_out_i;
  logic port_one_data_out_i, port_two_bit_clock_out_i, port_two_data_out_i, merged_port_word_clock_out_i;
  logic merged_port_bit_clock_out_i, merged_port_data_out_i;
  logic pin_b_i, pin_b_o, pin_b_oe_o, pin_b_ie_o, pin_c_i, pin_c_o, pin_c_oe_o, pin_c_ie_o;
  logic pin_d_i, pin_d_o, pin_d_oe_o, pin_d_ie_o, pin_b_route_o, pin_c_route_o, pin_d_route_o;
  logic [15:0] pattern, src; // Source levels, bit k is source k
  logic [2:0] ext, pad, po, poe, pie, proute; // Per-pin views, bit 0 is pin b
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  assign {merged_port_data_out_i, merged_port_bit_clock_out_i, merged_port_word_clock_out_i, port_two_data_out_i,
    port_two_bit_clock_out_i, port_one_data_out_i, port_one_bit_clock_out_i, port_one_word_clock_out_i,
    irq_line_four_i, irq_line_three_i, irq_line_two_i, irq_line_one_i, irq_line_zero_i, general_clock_output_i,
    pdm_clock_i, shared_bitbang_level_i} = src;
  assign {pin_d_i, pin_c_i, pin_b_i} = pad;
  assign po = {pin_d_o, pin_c_o, pin_b_o};
  assign poe = {pin_d_oe_o, pin_c_oe_o, pin_b_oe_o};
  assign pie = {pin_d_ie_o, pin_c_ie_o, pin_b_ie_o};
  assign proute = {pin_d_route_o, pin_c_route_o, pin_b_route_o};

  mps_far_side i_mps_far_side (.pattern_i(pattern), .ext_i(ext), .pad_out_i(po), .pad_oe_i(poe), .src_o(src),
    .pad_o(pad));
  mps_pin_select i_mps_pin_select (.*);

  // 50 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Wait n edges, step clear
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // One access cycle, driven just after an edge, held to the next
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_wr_i = w;
    reg_rd_i = r;
    reg_addr_i = a;
    reg_wdata_i = d;
    tick(1);
  endtask

  function automatic logic [7:0] ofs(input int p);
    return p == 0 ? mps_pkg::PIN_B_OFS : p == 1 ? mps_pkg::PIN_C_OFS : mps_pkg::PIN_D_OFS;
  endfunction

  // Source index a code selects on a pin, -1 where no source drives
  function automatic int src_idx(input int p, input int c);
    case (c)
      4: return 0;
      5: return 1;
      6: return p == 0 ? 2 : p == 1 ? 4 : 3;
      7: return p == 1 ? -1 : 4;
      8, 9, 10: return c - 3;
      12, 17: return 8;
      13: return 9;
      16: return 10;
      18: return 11;
      21: return 12;
      27, 28, 29: return c - 14;
      default: return -1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    chk(pin_b_ie_o, 1'b1, "b listens");
    chk(pin_c_o, 1'b1, "c port data");
    chk(pin_d_oe_o, 1'b1, "d drives");
    for (int p = 0; p < 3; p++) begin
      bus(1'b0, 1'b1, ofs(p), 8'h00);
      chk(reg_rvalid_o, 1'b1, "rvalid");
      chk(reg_rdata_o, p==0 ? mps_pkg::PIN_B_RST : p==1 ? mps_pkg::PIN_C_RST : mps_pkg::PIN_D_RST, "rst");
    end
    bus(1'b1, 1'b0, mps_pkg::PIN_B_OFS, 8'ha3);
    bus(1'b1, 1'b0, mps_pkg::PIN_C_OFS, 8'h5c);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    chk(pin_b_oe_o, 1'b1, "drive");
    chk(pin_b_o, 1'b0, "static low");
    bus(1'b1, 1'b1, mps_pkg::PIN_B_OFS, 8'h43);
    chk(reg_rdata_o, 8'ha3, "old value");
    bus(1'b0, 1'b1, mps_pkg::PIN_B_OFS, 8'h00);
    chk(reg_rdata_o, 8'h43, "readback");
    chk(pin_b_o, 1'b1, "static high");
    reg_book_i = 8'h01;
    bus(1'b1, 1'b0, mps_pkg::PIN_B_OFS, 8'hff);
    reg_book_i = 8'h00;
    reg_page_i = 8'h02;
    bus(1'b1, 1'b0, mps_pkg::PIN_B_OFS, 8'hff);
    reg_page_i = 8'h01;
    bus(1'b0, 1'b1, mps_pkg::PIN_B_OFS, 8'h00);
    chk(reg_rdata_o, 8'h43, "miss ignored");
    bus(1'b0, 1'b1, 8'h41, 8'h00);
    chk(reg_rdata_o, mps_pkg::RD_NONE, "unmapped");
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    $display("test regs done");
  endtask

  // Every code on every pin, chosen source low then high
  task automatic t_codes();
    int k;
    logic drv;
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 32; c++) begin
        k = src_idx(p, c);
        drv = k >= 0 || c == 3;
        bus(1'b1, 1'b0, ofs(p), 8'h40 | 8'(c));
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        pattern = k >= 0 ? ~(16'h0001 << k) : 16'hffff;
        tick(1);
        chk(poe[p], drv, "oe");
        chk(pie[p], c == 1, "ie");
        chk(proute[p], 1'b0, "route idle");
        if (drv) chk(po[p], c == 3, "level 1st");
        pattern = k >= 0 ? 16'h0001 << k : 16'h0000;
        tick(1);
        if (drv) chk(po[p], 1'b1, "level 2nd");
        if (c == 1) begin
          ext[p] = 1'b1;
          tick(4);
          chk(proute[p], 1'b1, "route high");
          ext[p] = 1'b0;
          tick(4);
          chk(proute[p], 1'b0, "route low");
        end
      end
    end
    $display("test codes done");
  endtask

  // Reset in mid-run brings the registers back
  task automatic t_rereset();
    arst_n_i = 1'b0;
    tick(2);
    arst_n_i = 1'b1;
    tick(2);
    chk(pin_b_ie_o, 1'b1, "b listens");
    bus(1'b0, 1'b1, mps_pkg::PIN_D_OFS, 8'h00);
    chk(reg_rdata_o, mps_pkg::PIN_D_RST, "d reset value");
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    $display("test rereset done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Hang guard, far above the few hundred edges the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("CHECK FAILED at %0t: run took too long", $time);
      summarize();
    end
  end

  // Main sequence
  initial begin
    arst_n_i = 1'b0;
    {reg_wr_i, reg_rd_i} = 2'b00;
    {reg_book_i, reg_page_i, reg_addr_i, reg_wdata_i} = {8'h00, 8'h01, 8'h00, 8'h00};
    pattern = 16'h0400;
    ext = 3'h0;
    tick(2);
    arst_n_i = 1'b1;
    tick(2);
    t_regs();
    t_codes();
    t_rereset();
    summarize();
  end
endmodule

`default_nettype wire
